/* File: hdl/processor_hot_alert_profile.sv */
// processor-hot alert: trip sources, deglitch, pulse and option registers
//
// Contract
// RL1: low rail below threshold after 20 us filter
// RL2: rail threshold codes, reset code 01b
// RL3: extension holds pin low until clear
// RL4: minimum pulse width per code, reset 10b
// RL5: host writes clear 0, pin released
// RL6: nominal trip at limit plus ten percent
// RL7: nominal filter 1 ms or 50 ms
// RL8: discharge threshold in 512 mA steps
// RL9: zero discharge threshold trips permanently
// RL10: discharge threshold resets to 16384 mA
// RL11: discharge filter codes, reset code 01b
// RL12: all enables zero disables the alert
// RL13: per-source enables gate the alert
// RL14: battery removal fires one-shot pulse
// RL15: critical trip at 110 percent of limit
// RL16: critical filter codes, reset code 01b
// RL17: any enabled trip drives pin low
// RL18: counter filters restart on release
`timescale 1ns/1ps

module glitch_filter
    import alert_pkg::*;
(
    input wire logic sys_clk, // device clock
    input wire logic nrst, // async reset, low active
    input wire logic ce, // clock enable
    input wire logic raw, // unfiltered condition
    input wire logic [CNT_W-1:0] limit, // cycles to qualify
    output logic hit // qualified condition
);
    logic [CNT_W-1:0] cnt;

    // RL18: restart on release
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt <= '0;
            hit <= 1'b0;
        end
        else if (ce)
        begin
            if (!raw)
            begin
                cnt <= '0;
                hit <= 1'b0;
            end
            else if (cnt >= limit)
                hit <= 1'b1;
            else
                cnt <= cnt + 1'b1;
        end
    end
endmodule : glitch_filter

module processor_hot_alert_profile
    import alert_pkg::*;
#(
    parameter int unsigned NOM0_CYC = NOM_DEG_US[0] * 1000 / CLK_NS,
    parameter int unsigned NOM1_CYC = NOM_DEG_US[1] * 1000 / CLK_NS,
    parameter int unsigned CRIT1_CYC = CRIT_DEG_US[1] * 1000 / CLK_NS,
    parameter int unsigned CRIT2_CYC = CRIT_DEG_US[2] * 1000 / CLK_NS,
    parameter int unsigned CRIT3_CYC = CRIT_DEG_US[3] * 1000 / CLK_NS,
    parameter int unsigned DCHG0_CYC = DCHG_DEG_US[0] * 1000 / CLK_NS,
    parameter int unsigned DCHG1_CYC = DCHG_DEG_US[1] * 1000 / CLK_NS,
    parameter int unsigned DCHG2_CYC = DCHG_DEG_US[2] * 1000 / CLK_NS,
    parameter int unsigned DCHG3_CYC = DCHG_DEG_US[3] * 1000 / CLK_NS,
    parameter int unsigned WIDTH0_CYC = WIDTH_US[0] * 1000 / CLK_NS,
    parameter int unsigned WIDTH1_CYC = WIDTH_US[1] * 1000 / CLK_NS,
    parameter int unsigned WIDTH2_CYC = WIDTH_US[2] * 1000 / CLK_NS,
    parameter int unsigned WIDTH3_CYC = WIDTH_US[3] * 1000 / CLK_NS
)
(
    input wire logic sys_clk, // device clock
    input wire logic nrst, // async reset, low active
    input wire logic ce, // clock enable, freezes all state
    input wire logic reg_wr, // register write strobe
    input wire logic reg_rd, // register read strobe
    input wire logic [7:0] reg_addr, // register command code
    input wire logic [15:0] reg_wdata, // write data
    output logic [15:0] reg_rdata, // read data, one cycle after strobe
    input wire sense_t sense, // measured rail, currents, status
    output logic processor_hot_alert_n, // alert pin level driven
    output logic processor_hot_alert_oe // high while pin pulled low
);
    // ------------------------------------------------------------
    // option registers
    // ------------------------------------------------------------
    logic [15:0] opt0;
    logic [15:0] opt1;
    logic wr0;
    logic wr1;

    assign wr0 = reg_wr && (reg_addr == OPT_PRIMARY_ADDR);
    assign wr1 = reg_wr && (reg_addr == OPT_SECONDARY_ADDR);

    // RL2: reset code of the primary option register
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            opt0 <= OPT_PRIMARY_RST;
        else if (ce)
        begin
            if (wr0)
                opt0 <= reg_wdata;
            // RL5: clear is consumed, returns to idle
            else if (!opt0[CLEAR_BIT])
                opt0[CLEAR_BIT] <= 1'b1;
        end
    end

    // RL10: discharge threshold resets to code 100000
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            opt1 <= OPT_SECONDARY_RST;
        else if (ce && wr1)
            opt1 <= reg_wdata;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            reg_rdata <= 16'h0000;
        else if (ce && reg_rd)
        begin
            case (reg_addr)
                OPT_PRIMARY_ADDR: reg_rdata <= opt0;
                OPT_SECONDARY_ADDR: reg_rdata <= opt1;
                default: reg_rdata <= 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // raw trip conditions
    // ------------------------------------------------------------
    logic [1:0] sys_code;
    logic [15:0] sys_th;
    logic [4:0] lim2_code;
    logic [31:0] lim2_pct;
    logic [5:0] dchg_code;
    logic lowv_raw;
    logic nom_raw;
    logic crit_raw;
    logic dchg_raw;

    assign sys_code = opt0[SYS_TH_LSB +: 2];
    assign lim2_code = opt0[SECOND_LIMIT_LSB +: 5];
    assign dchg_code = opt1[DCHG_TH_LSB +: 6];
    // RL2: threshold by code and pack size
    assign sys_th = sense.one_cell ? SYS_TH_SINGLE[sys_code]
        : SYS_TH_MULTI[sys_code];
    // RL1: rail below threshold
    assign lowv_raw = sense.system_rail_voltage_mv < sys_th;
    // RL6: limit plus ten percent
    assign nom_raw = ({16'h0000, sense.input_current_ma} * 32'd10) >
        ({16'h0000, sense.input_current_limit_setting_ma} * 32'd11);

    // second limit in percent; codes 0 and 31 are out of range
    always_comb
    begin
        lim2_pct = 32'd0;
        if (lim2_code >= 5'd1 && lim2_code <= 5'd25)
            lim2_pct = 32'd105 + 32'd5 * {27'h0, lim2_code};
        else if (lim2_code >= 5'd26 && lim2_code <= 5'd30)
            lim2_pct = 32'd250 + 32'd50 * {27'h0, lim2_code - 5'd26};
    end

    // RL15: 110 percent of the second limit
    assign crit_raw = (lim2_pct != 32'd0) &&
        (({16'h0000, sense.input_current_ma} * 32'd10000) >
        ({16'h0000, sense.input_current_limit_setting_ma} * lim2_pct
        * 32'd110));
    // RL8: threshold in 512 mA steps
    // RL9: zero threshold always trips
    assign dchg_raw = (dchg_code == 6'h00) ||
        ({1'b0, sense.battery_discharge_current_ma} >
        {1'b0, dchg_code, 10'h000} >> 1);

    // ------------------------------------------------------------
    // deglitch filters
    // ------------------------------------------------------------
    logic [CNT_W-1:0] nom_lim;
    logic [CNT_W-1:0] crit_lim;
    logic [CNT_W-1:0] dchg_lim;
    logic [CNT_W-1:0] width_lim;
    logic lowv_hit;
    logic nom_hit;
    logic crit_hit;
    logic dchg_hit;

    always_comb
    begin
        // RL7: nominal filter select
        nom_lim = opt0[NOM_DEG_BIT] ? CNT_W'(NOM1_CYC) : CNT_W'(NOM0_CYC);
        // RL16: critical filter select
        case (opt0[CRIT_DEG_LSB +: 2])
            2'b00: crit_lim = CNT_W'(CRIT0_CYC);
            2'b01: crit_lim = CNT_W'(CRIT1_CYC);
            2'b10: crit_lim = CNT_W'(CRIT2_CYC);
            default: crit_lim = CNT_W'(CRIT3_CYC);
        endcase
        // RL11: discharge filter select
        case (opt1[DCHG_DEG_LSB +: 2])
            2'b00: dchg_lim = CNT_W'(DCHG0_CYC);
            2'b01: dchg_lim = CNT_W'(DCHG1_CYC);
            2'b10: dchg_lim = CNT_W'(DCHG2_CYC);
            default: dchg_lim = CNT_W'(DCHG3_CYC);
        endcase
        // RL4: minimum width select
        case (opt0[WIDTH_LSB +: 2])
            2'b00: width_lim = CNT_W'(WIDTH0_CYC);
            2'b01: width_lim = CNT_W'(WIDTH1_CYC);
            2'b10: width_lim = CNT_W'(WIDTH2_CYC);
            default: width_lim = CNT_W'(WIDTH3_CYC);
        endcase
    end

    // RL1: fixed rail filter
    glitch_filter u_lowv (.sys_clk(sys_clk), .nrst(nrst), .ce(ce),
        .raw(lowv_raw), .limit(CNT_W'(SYS_DEG_CYC)), .hit(lowv_hit));
    glitch_filter u_nom (.sys_clk(sys_clk), .nrst(nrst), .ce(ce),
        .raw(nom_raw), .limit(nom_lim), .hit(nom_hit));
    glitch_filter u_crit (.sys_clk(sys_clk), .nrst(nrst), .ce(ce),
        .raw(crit_raw), .limit(crit_lim), .hit(crit_hit));
    glitch_filter u_dchg (.sys_clk(sys_clk), .nrst(nrst), .ce(ce),
        .raw(dchg_raw), .limit(dchg_lim), .hit(dchg_hit));

    // ------------------------------------------------------------
    // source combination
    // ------------------------------------------------------------
    logic batt_q;
    logic batt_fall;
    logic any_en;
    logic trip_level;
    logic start;

    // reset to absent so a battery missing at power-up is no edge
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            batt_q <= 1'b0;
        else if (ce)
            batt_q <= sense.battery_present;
    end

    // RL14: falling edge of presence
    assign batt_fall = opt1[BATT_EN_BIT] && batt_q && !sense.battery_present;
    // RL12: no enable, no alert
    assign any_en = |opt1[6:0];
    // RL13: per-source gating
    // RL17: sources are OR-ed
    assign trip_level = (opt1[COMP_EN_BIT] && sense.comparator_trip) ||
        (opt1[CRIT_EN_BIT] && crit_hit) || (opt1[NOM_EN_BIT] && nom_hit) ||
        (opt1[DCHG_EN_BIT] && dchg_hit) || (opt1[LOWV_EN_BIT] && lowv_hit);
    assign start = any_en && (trip_level || batt_fall);

    // ------------------------------------------------------------
    // pulse generator
    // ------------------------------------------------------------
    alert_state_t state;
    logic [CNT_W-1:0] wcnt;

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= ST_IDLE;
            wcnt <= '0;
        end
        else if (ce)
        begin
            case (state)
                ST_IDLE:
                begin
                    wcnt <= '0;
                    if (start)
                        state <= opt0[EXTEND_BIT] ? ST_HOLD : ST_PULSE;
                end
                // RL4: stay low at least the width, longer while tripped
                ST_PULSE:
                begin
                    if (wcnt < width_lim)
                        wcnt <= wcnt + 1'b1;
                    else if (opt0[EXTEND_BIT])
                        state <= ST_HOLD;
                    else if (!(any_en && trip_level))
                        state <= ST_IDLE;
                end
                // RL3: held until host clear
                ST_HOLD:
                begin
                    if (!opt0[CLEAR_BIT] || !opt0[EXTEND_BIT])
                        state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // RL17: pin low whenever a pulse is active
    assign processor_hot_alert_oe = (state != ST_IDLE);
    assign processor_hot_alert_n = 1'b0;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sequence s_trip_idle;
        ce && start && state == ST_IDLE;
    endsequence
    sequence s_released;
        ce && state == ST_HOLD && !opt0[CLEAR_BIT];
    endsequence

    property p_trip_drives;
        s_trip_idle |=> processor_hot_alert_oe;
    endproperty
    a_trip_drives: assert property (p_trip_drives) // RL17
        else $error("trip did not pull the alert pin low");
    property p_disabled;
        ce && !any_en && state == ST_IDLE |=> state == ST_IDLE;
    endproperty
    a_disabled: assert property (p_disabled) // RL12
        else $error("alert raised with every source disabled");
    property p_release;
        s_released |=> !processor_hot_alert_oe && opt0[CLEAR_BIT];
    endproperty
    a_release: assert property (p_release) // RL5
        else $error("host clear did not release the pin");
    property p_hold;
        ce && state == ST_HOLD && opt0[CLEAR_BIT] && opt0[EXTEND_BIT]
            && !wr0 |=> state == ST_HOLD;
    endproperty
    a_hold: assert property (p_hold) // RL3
        else $error("extended alert ended without clear");
    property p_min_width;
        ce && state == ST_PULSE && wcnt < width_lim |=> state == ST_PULSE;
    endproperty
    a_min_width: assert property (p_min_width) // RL4
        else $error("alert pulse shorter than selected width");
    property p_filter_restart;
        ce && !lowv_raw |=> !lowv_hit ##1 !lowv_hit [*1];
    endproperty
    a_filter_restart: assert property (p_filter_restart) // RL18
        else $error("rail filter kept its hit after release");
    property p_zero_dchg;
        ce && dchg_code == 6'h00 |=> u_dchg.cnt != '0 || dchg_hit;
    endproperty
    a_zero_dchg: assert property (p_zero_dchg) // RL9
        else $error("zero discharge threshold did not trip");
    property p_batt_shot;
        ce && batt_fall && state == ST_IDLE |=> state != ST_IDLE;
    endproperty
    a_batt_shot: assert property (p_batt_shot) // RL14
        else $error("battery removal gave no alert pulse");
endmodule : processor_hot_alert_profile

/* File: include/alert_pkg.sv */
// constants, field layout and carrier types for the processor-hot alert block
package alert_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] OPT_PRIMARY_ADDR = 8'h33;
    localparam logic [7:0] OPT_SECONDARY_ADDR = 8'h34;
    localparam logic [15:0] OPT_PRIMARY_RST = 16'h4a54;
    localparam logic [15:0] OPT_SECONDARY_RST = 16'h8120;
    localparam int SECOND_LIMIT_LSB = 11;
    localparam int CRIT_DEG_LSB = 9;
    localparam int SYS_TH_LSB = 6;
    localparam int EXTEND_BIT = 5;
    localparam int WIDTH_LSB = 3;
    localparam int CLEAR_BIT = 2;
    localparam int NOM_DEG_BIT = 1;
    localparam int DCHG_TH_LSB = 10;
    localparam int DCHG_DEG_LSB = 8;
    localparam int COMP_EN_BIT = 6;
    localparam int CRIT_EN_BIT = 5;
    localparam int NOM_EN_BIT = 4;
    localparam int DCHG_EN_BIT = 3;
    localparam int LOWV_EN_BIT = 2;
    localparam int BATT_EN_BIT = 1;
    localparam int DCHG_STEP_SHIFT = 9;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CNT_W = 24;
    localparam int unsigned CLK_NS = 10;
    localparam int unsigned SYS_DEG_US = 20;
    localparam int unsigned NOM_DEG_US[2] = '{1000, 50000};
    localparam int unsigned CRIT_DEG_US[4] = '{15, 100, 400, 800};
    localparam int unsigned DCHG_DEG_US[4] = '{1600, 100, 6000, 12000};
    localparam int unsigned WIDTH_US[4] = '{100, 1000, 10000, 5000};
    localparam int unsigned SYS_DEG_CYC = SYS_DEG_US * 1000 / CLK_NS;
    localparam int unsigned CRIT0_CYC = CRIT_DEG_US[0] * 1000 / CLK_NS;
    // ------------------------------------------------------------
    // thresholds in mV, code 0..3, multi-cell and single-cell packs
    // ------------------------------------------------------------
    localparam logic [15:0] SYS_TH_MULTI[4] = '{16'd5750, 16'd6000,
        16'd6250, 16'd6500};
    localparam logic [15:0] SYS_TH_SINGLE[4] = '{16'd2850, 16'd3100,
        16'd3350, 16'd3600};
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] system_rail_voltage_mv;
        logic [15:0] input_current_ma;
        logic [15:0] input_current_limit_setting_ma;
        logic [15:0] battery_discharge_current_ma;
        logic one_cell;
        logic battery_present;
        logic comparator_trip;
    } sense_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_PULSE = 3'b010,
        ST_HOLD = 3'b100
    } alert_state_t;
endpackage : alert_pkg

/* File: sim/alert_host_model.sv */
// host side model: watches the alert pin and measures each pulse
`timescale 1ns/1ps

module alert_host_model (
    input wire logic sys_clk, // device clock
    input wire logic alert_oe, // device pulls pin low
    output logic pin_level, // wire level with pull-up
    output int pulse_count, // finished pulses seen
    output int last_width // cycles low in last pulse
);
    int run;

    assign pin_level = alert_oe ? 1'b0 : 1'b1;

    // width is counted in whole clock cycles, as the host would sample it
    always @(posedge sys_clk)
    begin
        if (pin_level === 1'b0)
        begin
            run = run + 1;
        end
        else if (run != 0)
        begin
            last_width = run;
            pulse_count = pulse_count + 1;
            run = 0;
        end
    end
endmodule : alert_host_model

/* File: sim/processor_hot_alert_profile_bench.sv */
// self-checking bench for the processor-hot alert block
`timescale 1ns/1ps

module processor_hot_alert_profile_bench;
    import alert_pkg::*;
    // width 0 keeps its real length, the others are shortened below
    localparam int WID[4] = '{int'(WIDTH_US[0] * 1000 / CLK_NS), 30, 50,
        40};
    localparam int DCHG_FILT = int'(DCHG_DEG_US[1] * 1000 / CLK_NS);
    logic ce = 1'b1;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic [15:0] rv;
    sense_t sense;
    logic alert_n;
    logic oe;
    logic pin;
    int pulses;
    int width;
    int n;
    int err_total = 0;
    int num_checks = 0;

    always #5 sys_clk = ~sys_clk;

    processor_hot_alert_profile #(.NOM0_CYC(20), .NOM1_CYC(40),
        .WIDTH1_CYC(30), .WIDTH2_CYC(50), .WIDTH3_CYC(40))
    processor_hot_alert_profile_inst (
        .sys_clk(sys_clk), .nrst(nrst), .ce(ce), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .sense(sense),
        .processor_hot_alert_n(alert_n), .processor_hot_alert_oe(oe));

    alert_host_model alert_host_model_inst (
        .sys_clk(sys_clk), .alert_oe(oe), .pin_level(pin),
        .pulse_count(pulses), .last_width(width));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic chk_in(input string what, input int lo, input int hi,
        input int got);
        num_checks++;
        if (got < lo || got > hi)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo,
                hi, got);
        end
    endtask : chk_in

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge sys_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask : rd

    // bounded wait on the alert enable, counted in cycles
    task automatic wait_oe(input logic lvl, input int maxc, output int k);
        k = 0;
        while (oe !== lvl && k < maxc)
        begin
            @(negedge sys_clk);
            k++;
        end
    endtask : wait_oe

    // let the host model see the release before reading its width
    task automatic end_pulse();
        wait_oe(1'b0, WID[0] + 100, n);
        @(negedge sys_clk);
        chk("pulse end", 16'h0000, {15'h0000, oe});
    endtask : end_pulse

    task automatic comp_blip();
        @(negedge sys_clk);
        sense.comparator_trip = 1'b1;
        @(negedge sys_clk);
        sense.comparator_trip = 1'b0;
    endtask : comp_blip

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd(OPT_PRIMARY_ADDR, rv);
        chk("opt primary", 16'h4a54, rv);
        rd(OPT_SECONDARY_ADDR, rv);
        chk("opt secondary", 16'h8120, rv);
        rd(8'h35, rv);
        chk("unmapped", 16'h0000, rv);
        chk("idle oe", 16'h0000, {15'h0000, oe});
        chk("pin drive", 16'h0000, {15'h0000, alert_n});
        $display("test reset done");
    endtask : t_reset

    task automatic t_disch();
        sense.battery_discharge_current_ma = 16'd1024;
        wr(OPT_SECONDARY_ADDR, 16'h0908);
        repeat (40) @(negedge sys_clk);
        chk("dchg at limit", 16'h0000, {15'h0000, oe});
        sense.battery_discharge_current_ma = 16'd1025;
        wait_oe(1'b1, DCHG_FILT + 100, n);
        chk_in("dchg filter", DCHG_FILT + 1, DCHG_FILT + 4, n);
        chk("dchg above", 16'h0001, {15'h0000, oe});
        sense.battery_discharge_current_ma = 16'd0;
        end_pulse();
        chk_in("default width", 51, 54, width);
        wr(OPT_SECONDARY_ADDR, 16'h0108);
        wait_oe(1'b1, DCHG_FILT + 100, n);
        chk("zero threshold", 16'h0001, {15'h0000, oe});
        wr(OPT_SECONDARY_ADDR, 16'h0000);
        end_pulse();
        repeat (60) @(negedge sys_clk);
        chk("all disabled", 16'h0000, {15'h0000, oe});
        $display("test discharge done");
    endtask : t_disch

    task automatic t_nom();
        wr(OPT_SECONDARY_ADDR, 16'h0010);
        sense.input_current_ma = 16'd1100;
        repeat (40) @(negedge sys_clk);
        chk("nom at limit", 16'h0000, {15'h0000, oe});
        sense.input_current_ma = 16'd1101;
        repeat (12) @(negedge sys_clk);
        sense.input_current_ma = 16'd0;
        repeat (2) @(negedge sys_clk);
        sense.input_current_ma = 16'd1101;
        repeat (12) @(negedge sys_clk);
        chk("nom restart", 16'h0000, {15'h0000, oe});
        wait_oe(1'b1, 30, n);
        chk("nom trip", 16'h0001, {15'h0000, oe});
        sense.input_current_ma = 16'd0;
        end_pulse();
        wr(OPT_PRIMARY_ADDR, 16'h4a56);
        sense.input_current_ma = 16'd1101;
        wait_oe(1'b1, 100, n);
        chk_in("nom long filter", 40, 44, n);
        sense.input_current_ma = 16'd0;
        end_pulse();
        $display("test nominal done");
    endtask : t_nom

    task automatic t_crit();
        wr(OPT_SECONDARY_ADDR, 16'h0020);
        wr(OPT_PRIMARY_ADDR, 16'h0854);
        sense.input_current_ma = 16'd1210;
        repeat (1600) @(negedge sys_clk);
        chk("crit at limit", 16'h0000, {15'h0000, oe});
        sense.input_current_ma = 16'd1211;
        wait_oe(1'b1, 1600, n);
        chk_in("crit filter", CRIT0_CYC + 1, CRIT0_CYC + 4, n);
        sense.input_current_ma = 16'd0;
        end_pulse();
        $display("test critical done");
    endtask : t_crit

    task automatic t_ext();
        wr(OPT_SECONDARY_ADDR, 16'h0040);
        wr(OPT_PRIMARY_ADDR, 16'h4a74);
        comp_blip();
        repeat (100) @(negedge sys_clk);
        chk("extended hold", 16'h0001, {15'h0000, oe});
        ce = 1'b0;
        wr(OPT_PRIMARY_ADDR, 16'h4a70);
        repeat (3) @(negedge sys_clk);
        chk("frozen hold", 16'h0001, {15'h0000, oe});
        ce = 1'b1;
        rd(OPT_PRIMARY_ADDR, rv);
        chk("frozen write", 16'h4a74, rv);
        wr(OPT_PRIMARY_ADDR, 16'h4a70);
        wait_oe(1'b0, 4, n);
        chk("host clear", 16'h0000, {15'h0000, oe});
        rd(OPT_PRIMARY_ADDR, rv);
        chk("clear restored", 16'h4a74, rv);
        $display("test extension done");
    endtask : t_ext

    task automatic t_width();
        for (int c = 0; c < 4; c++)
        begin
            wr(OPT_PRIMARY_ADDR, 16'h4a44 | (16'(c) << 3));
            comp_blip();
            end_pulse();
            chk_in("pulse width", WID[c] + 1, WID[c] + 3, width);
        end
        $display("test width done");
    endtask : t_width

    task automatic t_batt();
        int p0;
        wr(OPT_PRIMARY_ADDR, 16'h4a54);
        wr(OPT_SECONDARY_ADDR, 16'h0002);
        p0 = pulses;
        sense.battery_present = 1'b0;
        wait_oe(1'b1, 3, n);
        chk("removal alert", 16'h0001, {15'h0000, oe});
        end_pulse();
        repeat (60) @(negedge sys_clk);
        chk("one shot", 16'h0000, {15'h0000, oe});
        chk_in("removal width", 51, 54, width);
        chk_in("pulse count", p0 + 1, p0 + 1, pulses);
        $display("test battery done");
    endtask : t_batt

    task automatic t_lowv();
        wr(OPT_SECONDARY_ADDR, 16'h0004);
        sense.system_rail_voltage_mv = 16'd6000;
        repeat (2100) @(negedge sys_clk);
        chk("rail at threshold", 16'h0000, {15'h0000, oe});
        sense.system_rail_voltage_mv = 16'd5999;
        repeat (1990) @(negedge sys_clk);
        chk("rail filtering", 16'h0000, {15'h0000, oe});
        wait_oe(1'b1, 30, n);
        chk("rail trip", 16'h0001, {15'h0000, oe});
        sense.system_rail_voltage_mv = 16'd7000;
        end_pulse();
        sense.one_cell = 1'b1;
        sense.system_rail_voltage_mv = 16'd3100;
        repeat (2100) @(negedge sys_clk);
        chk("one cell at threshold", 16'h0000, {15'h0000, oe});
        sense.system_rail_voltage_mv = 16'd3099;
        wait_oe(1'b1, 2100, n);
        chk_in("one cell trip", SYS_DEG_CYC + 1, SYS_DEG_CYC + 4, n);
        sense.system_rail_voltage_mv = 16'd7000;
        end_pulse();
        $display("test low rail done");
    endtask : t_lowv

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    // sense idles with no trip: input current 0 keeps the critical source off
    initial
    begin
        sense = '0;
        sense.system_rail_voltage_mv = 16'd7000;
        sense.input_current_limit_setting_ma = 16'd1000;
        sense.battery_present = 1'b1;
        repeat (6) @(negedge sys_clk);
        nrst = 1'b1;
        t_reset();
        t_disch();
        t_nom();
        t_crit();
        t_ext();
        t_width();
        t_batt();
        t_lowv();
        end_of_test();
    end

    initial
    begin
        #700000;
        err_total++;
        end_of_test();
    end
endmodule : processor_hot_alert_profile_bench
